// ---- verilog/ptm_pkg.sv ----
package ptm_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_PENDING   = 32'h4000_4000;
	localparam logic [31:0] ADDR_CONTROL   = 32'h4000_4004;
	localparam logic [31:0] ADDR_TCOUNT    = 32'h4000_4008;
	localparam logic [31:0] ADDR_PLIMIT    = 32'h4000_400C;
	localparam logic [31:0] ADDR_PCOUNT    = 32'h4001_4010;
	localparam logic [31:0] ADDR_MACTION   = 32'h4000_4014;
	localparam logic [31:0] ADDR_MVALUE0   = 32'h4000_4018;
	localparam logic [31:0] MVALUE_STRIDE  = 32'h0000_0004;

	// register indices used inside the block
	localparam logic [3:0] IDX_PENDING = 4'h0;
	localparam logic [3:0] IDX_CONTROL = 4'h1;
	localparam logic [3:0] IDX_TCOUNT  = 4'h2;
	localparam logic [3:0] IDX_PLIMIT  = 4'h3;
	localparam logic [3:0] IDX_PCOUNT  = 4'h4;
	localparam logic [3:0] IDX_MACTION = 4'h5;
	localparam logic [3:0] IDX_MVALUE0 = 4'h6;

	localparam int          NUM_CH       = 4;
	localparam int          COUNT_W      = 32;
	localparam int          CTL_ENABLE   = 0;
	localparam int          CTL_CLEAR    = 1;
	localparam int          MACT_STRIDE  = 3;
	localparam int          MACT_IRQ     = 0;
	localparam int          MACT_RESET   = 1;
	localparam int          MACT_STOP    = 2;
	localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES     = 32'hFFFF_FFFF;

	// one bus access as seen by the register file
	typedef struct packed {
		logic        wr;
		logic        hit;
		logic [3:0]  idx;
		logic [31:0] wdata;
	} ptm_req_t;

	// byte address to register index; hit low when unmapped
	function automatic logic [4:0] ptm_decode(input logic [31:0] addr);
		logic [4:0] res;
		res = 5'h00;
		unique case (addr)
			ADDR_PENDING: res = {1'b1, IDX_PENDING};
			ADDR_CONTROL: res = {1'b1, IDX_CONTROL};
			ADDR_TCOUNT:  res = {1'b1, IDX_TCOUNT};
			ADDR_PLIMIT:  res = {1'b1, IDX_PLIMIT};
			ADDR_PCOUNT:  res = {1'b1, IDX_PCOUNT};
			ADDR_MACTION: res = {1'b1, IDX_MACTION};
			default: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (addr == ADDR_MVALUE0 + MVALUE_STRIDE * 32'(i)) begin
						res = {1'b1, 4'(IDX_MVALUE0 + 4'(i))};
					end
				end
			end
		endcase
		return res;
	endfunction

endpackage

// ---- verilog/ptm_apb_slave.sv ----
`timescale 1ns/1ns
module ptm_apb_slave (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	output ptm_pkg::ptm_req_t      req,
	input  wire logic [31:0]       rd_value
);

	logic [4:0]  dec;
	logic [31:0] prdata_r;

	// decode on the live address; master holds it through the access
	assign dec       = ptm_pkg::ptm_decode(paddr);
	assign req.wr    = psel & penable & pwrite & dec[4];
	assign req.hit   = dec[4];
	assign req.idx   = dec[3:0];
	assign req.wdata = pwdata;

	// zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~dec[4];
	assign prdata  = prdata_r;

	// read data captured in setup so it comes from a flop in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= ptm_pkg::RESET_VALUE;
		end else if (psel && !penable) begin
			prdata_r <= (dec[4] && !pwrite) ? rd_value : ptm_pkg::RESET_VALUE;
		end
	end

endmodule

// ---- verilog/ptm_match_unit.sv ----
`timescale 1ns/1ns
module ptm_match_unit #(
	parameter int NCH = 4,
	parameter int W   = 32
) (
	input  wire logic [W-1:0]   count,
	input  wire logic [W-1:0]   value [NCH],
	input  wire logic           fresh,
	output logic [NCH-1:0]      equal,
	output logic [NCH-1:0]      first
);

	// continuous comparison of every channel against the counter
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			equal[i] = (count == value[i]);
		end
	end

	// a match is reported once per arrival of the counter at the value
	assign first = equal & {NCH{fresh}};

endmodule

// ---- verilog/ptm_timer_core.sv ----
`timescale 1ns/1ns
// Summary of operation
// [RULE1] one pending flag per match channel, set when that channel interrupted
// [RULE2] writing one clears a pending flag, writing zero leaves it alone
// [RULE3] flag bits 0..3 map to channels 0..3, bits 31:4 read zero
// [RULE4] enable bit one lets both counters count, zero holds them
// [RULE5] clear bit one zeroes both counters each edge until it returns to zero
// [RULE6] timer counter steps at prescale terminal count, wraps all-ones to zero
// [RULE7] no flag and no interrupt on counter wrap
// [RULE8] prescale counter steps each enabled clock, returns to zero at limit
// [RULE9] timer counter advances once per limit plus one clocks
// [RULE10] prescale limit register is 32 bits and bounds the prescale counter
// [RULE11] channel irq enable bit plus match sets that channel's pending flag
// [RULE12] channel reset enable bit makes a match reset the timer counter
// [RULE13] channel stop enable bit halts both counters and clears enable bit
// [RULE14] each match value is compared to the counter continuously
// [RULE15] flag rises one clock after the match; reset keeps a full cycle
// [RULE16] a match in the clearing cycle wins over the clear
module ptm_timer_core #(
	parameter int NCH = ptm_pkg::NUM_CH
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic                              pready,
	output logic                              pslverr,
	output logic [31:0]                       prdata,
	output logic [ptm_pkg::COUNT_W-1:0]       count_value,
	output logic [NCH-1:0]                    match_equal
);

	// refuse channel counts the action register layout cannot serve
	if (NCH < 1 || NCH > ptm_pkg::NUM_CH) begin : g_bad_nch
		$error("channel count out of range");
	end

	localparam int W = ptm_pkg::COUNT_W;

	ptm_pkg::ptm_req_t req;
	logic [31:0]       rd_value;
	logic [NCH-1:0]    pend_r;
	logic [NCH-1:0]    pend_nxt;
	logic              cen_r;
	logic              clr_r;
	logic [W-1:0]      tc_r;
	logic [W-1:0]      tc_nxt;
	logic [W-1:0]      pc_r;
	logic [W-1:0]      pc_nxt;
	logic [W-1:0]      pr_r;
	logic [11:0]       mact_r;
	logic [W-1:0]      mval_r [NCH];
	logic              fresh_r;
	logic              fresh_nxt;
	logic [NCH-1:0]    eq;
	logic [NCH-1:0]    first;
	logic [NCH-1:0]    irq_en;
	logic [NCH-1:0]    rst_en;
	logic [NCH-1:0]    stop_en;
	logic              tick;
	logic              do_reset;
	logic              do_stop;
	logic              wr_tc;
	logic              wr_pc;
	logic              wr_pend;

	ptm_apb_slave u_apb (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.prdata   (prdata),
		.req      (req),
		.rd_value (rd_value)
	);

	ptm_match_unit #(
		.NCH (NCH),
		.W   (W)
	) u_match (
		.count (tc_r),
		.value (mval_r),
		.fresh (fresh_r),
		.equal (eq),
		.first (first)
	);

	// per-channel action bits pulled out of the action register
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			irq_en[i]  = mact_r[i*ptm_pkg::MACT_STRIDE + ptm_pkg::MACT_IRQ];
			rst_en[i]  = mact_r[i*ptm_pkg::MACT_STRIDE + ptm_pkg::MACT_RESET];
			stop_en[i] = mact_r[i*ptm_pkg::MACT_STRIDE + ptm_pkg::MACT_STOP];
		end
	end

	assign wr_tc   = req.wr && req.idx == ptm_pkg::IDX_TCOUNT;
	assign wr_pc   = req.wr && req.idx == ptm_pkg::IDX_PCOUNT;
	assign wr_pend = req.wr && req.idx == ptm_pkg::IDX_PENDING;

	// terminal prescale count while enabled; the timer steps on this edge
	assign tick     = cen_r && !clr_r && (pc_r == pr_r);                   // [RULE8] [RULE9]
	// actions wait for the terminal count so the matched value lasts a full step
	assign do_reset = tick && |(eq & rst_en);                              // [RULE12] [RULE15]
	assign do_stop  = tick && |(eq & stop_en);                             // [RULE13]

	// counter next values: clear bit, then bus write, then counting
	always_comb begin
		tc_nxt = tc_r;
		pc_nxt = pc_r;
		if (clr_r) begin
			tc_nxt = ptm_pkg::RESET_VALUE;                                 // [RULE5]
			pc_nxt = ptm_pkg::RESET_VALUE;                                 // [RULE5]
		end else begin
			if (cen_r) begin                                               // [RULE4]
				pc_nxt = tick ? ptm_pkg::RESET_VALUE : pc_r + 32'h0000_0001; // [RULE8] [RULE10]
			end
			if (do_reset) begin
				tc_nxt = ptm_pkg::RESET_VALUE;                             // [RULE12]
			end else if (tick && !do_stop) begin
				tc_nxt = tc_r + 32'h0000_0001;                             // [RULE6] wraps naturally
			end
			if (wr_tc) begin
				tc_nxt = req.wdata;
			end
			if (wr_pc) begin
				pc_nxt = req.wdata;
			end
		end
	end

	// a new counter value arms the comparators for one report
	// a counter write while clearing is dropped, so it must not arm a report
	assign fresh_nxt = (tc_nxt != tc_r) || do_reset || (wr_tc && !clr_r); // [RULE14]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_r    <= ptm_pkg::RESET_VALUE;
			pc_r    <= ptm_pkg::RESET_VALUE;
			fresh_r <= 1'b0;
		end else begin
			tc_r    <= tc_nxt;
			pc_r    <= pc_nxt;
			fresh_r <= fresh_nxt;
		end
	end

	// control bits; a stop match beats a same-cycle software enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cen_r <= 1'b0;
			clr_r <= 1'b0;
		end else begin
			if (req.wr && req.idx == ptm_pkg::IDX_CONTROL) begin
				cen_r <= req.wdata[ptm_pkg::CTL_ENABLE];
				clr_r <= req.wdata[ptm_pkg::CTL_CLEAR];
			end
			if (do_stop) begin
				cen_r <= 1'b0;                                             // [RULE13]
			end
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pr_r   <= ptm_pkg::RESET_VALUE;
			mact_r <= 12'h000;
			for (int i = 0; i < NCH; i++) begin
				mval_r[i] <= ptm_pkg::RESET_VALUE;
			end
		end else if (req.wr) begin
			if (req.idx == ptm_pkg::IDX_PLIMIT) begin
				pr_r <= req.wdata;                                         // [RULE10]
			end
			if (req.idx == ptm_pkg::IDX_MACTION) begin
				mact_r <= req.wdata[11:0];
			end
			for (int i = 0; i < NCH; i++) begin
				if (req.idx == 4'(ptm_pkg::IDX_MVALUE0 + 4'(i))) begin
					mval_r[i] <= req.wdata;
				end
			end
		end
	end

	// pending flags: set from the match, cleared by writing one; set wins
	always_comb begin
		pend_nxt = pend_r;
		if (wr_pend) begin
			pend_nxt = pend_r & ~req.wdata[NCH-1:0];                       // [RULE2]
		end
		pend_nxt = pend_nxt | (first & irq_en);                            // [RULE11] [RULE16] [RULE7]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= '0;
		end else begin
			pend_r <= pend_nxt;                                            // [RULE1]
		end
	end

	// read mux; unused high bits read as zero
	always_comb begin
		rd_value = ptm_pkg::RESET_VALUE;
		unique case (req.idx)
			ptm_pkg::IDX_PENDING: rd_value = 32'(pend_r);                  // [RULE3]
			ptm_pkg::IDX_CONTROL: rd_value = {30'h0, clr_r, cen_r};
			ptm_pkg::IDX_TCOUNT:  rd_value = tc_r;
			ptm_pkg::IDX_PLIMIT:  rd_value = pr_r;
			ptm_pkg::IDX_PCOUNT:  rd_value = pc_r;
			ptm_pkg::IDX_MACTION: rd_value = 32'(mact_r);
			default: begin
				for (int i = 0; i < NCH; i++) begin
					if (req.idx == 4'(ptm_pkg::IDX_MVALUE0 + 4'(i))) begin
						rd_value = mval_r[i];
					end
				end
			end
		endcase
	end

	assign count_value = tc_r;
	assign match_equal = eq;

	// quiet cycle helper: no bus write and no clear
	logic quiet;
	assign quiet = !req.wr && !clr_r;

	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		wr_pend && req.wdata[0] && !(first[0] && irq_en[0]) |=> !pend_r[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared by one"); // [RULE2]

	property p_keep;
		@(posedge pclk) disable iff (!presetn)
		wr_pend && !req.wdata[0] && pend_r[0] |=> pend_r[0];
	endproperty
	a_keep: assert property (p_keep) else $error("flag lost on zero write"); // [RULE2]

	property p_set;
		@(posedge pclk) disable iff (!presetn)
		first[0] && irq_en[0] |=> pend_r[0];
	endproperty
	a_set: assert property (p_set) else $error("match did not set flag"); // [RULE11] [RULE16]

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		!cen_r && quiet |=> $stable(tc_r) && $stable(pc_r);
	endproperty
	a_hold: assert property (p_hold) else $error("counters moved while disabled"); // [RULE4]

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		clr_r ##1 clr_r |-> tc_r == 32'h0000_0000 && pc_r == 32'h0000_0000;
	endproperty
	a_clear: assert property (p_clear) else $error("counters not held clear"); // [RULE5]

	property p_step;
		@(posedge pclk) disable iff (!presetn)
		tick && !do_reset && !do_stop && quiet |=> tc_r == $past(tc_r) + 32'h0000_0001 && pc_r == 32'h0000_0000;
	endproperty
	a_step: assert property (p_step) else $error("timer did not step at terminal count"); // [RULE6]

	property p_prescale;
		@(posedge pclk) disable iff (!presetn)
		cen_r && !tick && quiet |=> pc_r == $past(pc_r) + 32'h0000_0001 && $stable(tc_r);
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescale count wrong"); // [RULE8] [RULE9]

	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		tick && tc_r == ptm_pkg::ALL_ONES && !do_reset && !do_stop && quiet && !first[0]
			|=> tc_r == 32'h0000_0000 && pend_r[0] == $past(pend_r[0]);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap misbehaved"); // [RULE7]

	property p_reset;
		@(posedge pclk) disable iff (!presetn)
		do_reset && quiet |=> tc_r == 32'h0000_0000;
	endproperty
	a_reset: assert property (p_reset) else $error("match reset failed"); // [RULE12]

	property p_stop;
		@(posedge pclk) disable iff (!presetn)
		do_stop && !do_reset && quiet |=> !cen_r && $stable(tc_r) ##1 $stable(tc_r);
	endproperty
	a_stop: assert property (p_stop) else $error("stop on match failed"); // [RULE13]

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == ptm_pkg::ADDR_PENDING |=> prdata[31:4] == 28'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved flag bits not zero"); // [RULE3]

endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic [31:0] count_value;
	logic [3:0]  match_equal;
	logic [31:0] rd;
	logic [31:0] v;
	logic        e;
	int          errors;
	int          checks_done;
	int          n;

	ptm_timer_core dut_u (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.prdata      (prdata),
		.count_value (count_value),
		.match_equal (match_equal)
	);

	// bus clock, 10 ns period
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic give_verdict();
		if (errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rdat, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        y;
		apb(1'b1, a, d, x, y);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
		logic [31:0] x;
		logic        y;
		apb(1'b0, a, 32'h0000_0000, x, y);
		chk(what, exp, x);
	endtask

	// cycles until the counter output changes; bounded
	task automatic gap(output int cnt);
		logic [31:0] old;
		cnt = 0;
		old = count_value;
		do begin
			@(posedge pclk);
			cnt++;
		end while (count_value === old && cnt < 1000);
	endtask

	task automatic wait_cnt(input logic [31:0] val);
		int k;
		k = 0;
		while (count_value !== val && k < 5000) begin
			@(posedge pclk);
			k++;
		end
		chk("count reached", val, count_value);
	endtask

	// stop, load limit/start, clear flags, load actions, then run
	task automatic go(input logic [31:0] lim, input logic [31:0] mact, input logic [31:0] start);
		wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0000);
		wr(ptm_pkg::ADDR_PLIMIT, lim);
		wr(ptm_pkg::ADDR_PCOUNT, 32'h0000_0000);
		wr(ptm_pkg::ADDR_TCOUNT, start);
		wr(ptm_pkg::ADDR_PENDING, 32'h0000_000F);
		wr(ptm_pkg::ADDR_MACTION, mact);
		wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0001);
	endtask

	// hang guard, far beyond the expected run length
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		give_verdict();
	end

	initial begin
		logic [31:0] regs [6];
		logic [31:0] lims [3];
		regs = '{ptm_pkg::ADDR_PENDING, ptm_pkg::ADDR_CONTROL, ptm_pkg::ADDR_TCOUNT,
			ptm_pkg::ADDR_PLIMIT, ptm_pkg::ADDR_PCOUNT, ptm_pkg::ADDR_MACTION};
		lims = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0004};
		errors = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped place
		foreach (regs[i]) begin
			rd_chk(regs[i], 32'h0000_0000, "reset value");
		end
		apb(1'b0, 32'h4000_4030, 32'h0000_0000, rd, e);
		chk("unmapped error", 32'h0000_0001, {31'h0, e});
		chk("unmapped data", 32'h0000_0000, rd);
		wr(ptm_pkg::ADDR_PLIMIT, 32'hA5A5_5A5A);
		rd_chk(ptm_pkg::ADDR_PLIMIT, 32'hA5A5_5A5A, "limit readback");
		// step period for several limits; first gap may be partial
		foreach (lims[i]) begin
			go(lims[i], 32'h0000_0000, 32'h0000_0000);
			gap(n);
			gap(n);
			chk("step period", lims[i] + 32'h1, 32'(n));
		end
		// disabling holds the counter
		wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0000);
		@(posedge pclk);
		v = count_value;
		repeat (6) @(posedge pclk);
		chk("held count", v, count_value);
		// clear bit keeps both counters at zero while set
		go(32'h0000_0003, 32'h0000_0000, 32'h0000_0000);
		repeat (9) @(posedge pclk);
		wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0003);
		repeat (4) @(posedge pclk);
		chk("cleared count", 32'h0000_0000, count_value);
		rd_chk(ptm_pkg::ADDR_PCOUNT, 32'h0000_0000, "cleared prescale");
		chk("still cleared", 32'h0000_0000, count_value);
		// each channel's interrupt enable sets only its own flag
		for (int ch = 0; ch < 4; ch++) begin
			wr(ptm_pkg::ADDR_MVALUE0 + 32'(4 * ch), 32'(20 + ch));
			go(32'h0000_0000, 32'h1 << (3 * ch), 32'h0000_0000);
			wait_cnt(32'(20 + ch));
			repeat (3) @(posedge pclk);
			wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0000);
			rd_chk(ptm_pkg::ADDR_PENDING, 32'h1 << ch, "flag set");
			wr(ptm_pkg::ADDR_PENDING, 32'hFFFF_FFF0);
			rd_chk(ptm_pkg::ADDR_PENDING, 32'h1 << ch, "flag kept");
			wr(ptm_pkg::ADDR_PENDING, 32'h1 << ch);
			rd_chk(ptm_pkg::ADDR_PENDING, 32'h0000_0000, "flag cleared");
		end
		// wrap past all-ones raises no flag, all interrupts enabled
		go(32'h0000_0000, 32'h0000_0249, 32'hFFFF_FFF0);
		wait_cnt(32'h0000_0003);
		wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0000);
		rd_chk(ptm_pkg::ADDR_PENDING, 32'h0000_0000, "wrap flags");
		// reset on match keeps the match value for a full step
		wr(ptm_pkg::ADDR_MVALUE0, 32'h0000_0004);
		go(32'h0000_0001, 32'h0000_0003, 32'h0000_0000);
		wait_cnt(32'h0000_0004);
		gap(n);
		chk("match step length", 32'h0000_0002, 32'(n));
		chk("reset on match", 32'h0000_0000, count_value);
		wait_cnt(32'h0000_0004);
		wr(ptm_pkg::ADDR_CONTROL, 32'h0000_0000);
		rd_chk(ptm_pkg::ADDR_PENDING, 32'h0000_0001, "reset match flag");
		// stop on match halts and drops the enable bit
		wr(ptm_pkg::ADDR_MVALUE0 + 32'h4, 32'h0000_0006);
		go(32'h0000_0000, 32'h0000_0020, 32'h0000_0000);
		wait_cnt(32'h0000_0006);
		repeat (5) @(posedge pclk);
		chk("stopped count", 32'h0000_0006, count_value);
		chk("match equal", 32'h0000_0002, 32'(match_equal));
		rd_chk(ptm_pkg::ADDR_CONTROL, 32'h0000_0000, "enable after stop");
		rd_chk(ptm_pkg::ADDR_PCOUNT, 32'h0000_0000, "prescale after stop");
		give_verdict();
	end
endmodule
